// ==== src/cwd_config_word_decoder.sv ====
module cwd_config_word_decoder #(
  parameter bit          LARGE_FLASH = 1'b0,
  // Part code value is arbitrary.
  parameter logic [8:0]  PART_CODE   = 9'h0A5,
  // Revision value is arbitrary.
  parameter logic [4:0]  SILICON_STEP = 5'h01
) (
  input  wire logic              MCLK,
  input  wire logic              RESET,
  input  wire logic [13:0]       NV_CFG_ONE,
  input  wire logic [13:0]       NV_CFG_TWO,
  input  wire logic              SOFTWARE_BROWNOUT_ENABLE,
  input  wire logic              SOFTWARE_WATCHDOG_ENABLE,
  input  wire logic              PORT_PULLUP_BIT,
  input  wire logic              IN_SLEEP,
  input  wire logic              STACK_FAULT,
  input  wire logic              EXT_PORT_REQ,
  input  wire logic [14:0]       SELF_WRITE_ADDR,
  input  wire logic [13:0]       FLASH_RDATA,
  output logic [13:0]            EXT_PORT_RDATA,
  output logic                   EXT_PORT_BLOCKED,
  output logic                   SELF_WRITE_BLOCKED,
  output logic                   STACK_FAULT_RESET,
  output logic                   BROWNOUT_ACTIVE,
  output logic                   WATCHDOG_ACTIVE,
  output cwd_pkg::cwd_ctrl_t     CTRL,
  input  wire logic [7:0]        AWADDR,
  input  wire logic              AWVALID,
  output logic                   AWREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  input  wire logic              WVALID,
  output logic                   WREADY,
  output logic [1:0]             BRESP,
  output logic                   BVALID,
  input  wire logic              BREADY,
  input  wire logic [7:0]        ARADDR,
  input  wire logic              ARVALID,
  output logic                   ARREADY,
  output logic [31:0]            RDATA,
  output logic [1:0]             RRESP,
  output logic                   RVALID,
  input  wire logic              RREADY
);
  typedef struct packed {
    logic [13:0]                 cfg_one;
    logic [13:0]                 cfg_two;
    logic [3:0][13:0]            user_id;
    logic                        erase_pending;
    logic                        lvp_session;
    logic                        refused;
    cwd_pkg::cwd_ctrl_t          ctrl;
    logic [13:0]                 port_rdata;
    logic                        port_blocked;
    cwd_pkg::cwd_axi_t           axi;
  } cwd_state_t;

  cwd_state_t st_reg;
  cwd_state_t st_next;

  function automatic cwd_pkg::cwd_ctrl_t decode(input logic [13:0] w1, input logic [13:0] w2);
    cwd_pkg::cwd_ctrl_t c;
    logic [1:0]         bor;
    logic [1:0]         wdt;
    logic [1:0]         self_write_protect_field;
    bor = w1[cwd_pkg::B1_BOR_LO +: 2];
    wdt = w1[cwd_pkg::B1_WDT_LO +: 2];
    self_write_protect_field = w2[cwd_pkg::B2_WRT_LO +: 2];
    c.clock_output_route  = ~w1[cwd_pkg::B1_CLOCK_OUTPUT_PIN]; // R3
    c.bor_always          = (bor == cwd_pkg::MODE_ALWAYS); // R4
    c.bor_run_only        = (bor == cwd_pkg::MODE_RUN); // R4
    c.bor_software        = (bor == cwd_pkg::MODE_SW); // R4
    c.code_protect_active = ~w1[cwd_pkg::B1_CP]; // R6
    c.low_voltage_program_enable = w2[cwd_pkg::B2_LVP]; // R14
    // R9
    c.pin_is_reset        = w2[cwd_pkg::B2_LVP] | w1[cwd_pkg::B1_RSTPIN];
    c.pin_pullup_forced   = c.pin_is_reset;
    c.powerup_timer_on    = ~w1[cwd_pkg::B1_POWERUP_TIMER]; // R5 R10
    c.wdt_always          = (wdt == cwd_pkg::MODE_ALWAYS); // R11
    c.wdt_run_only        = (wdt == cwd_pkg::MODE_RUN); // R11
    c.wdt_software        = (wdt == cwd_pkg::MODE_SW); // R11
    c.osc_mode            = cwd_pkg::cwd_osc_t'(w1[cwd_pkg::B1_OSC_LO +: 2]); // R12 R13
    c.clock_input_is_io   = (c.osc_mode == cwd_pkg::OSC_INTERNAL); // R12
    c.debugger_owns_pins  = ~w2[cwd_pkg::B2_DEBUG]; // R15
    c.low_power_bor_on    = ~w2[cwd_pkg::B2_LOW_POWER_BROWNOUT_ENABLE_N]; // R16
    c.bor_low_trip        = w2[cwd_pkg::B2_BROWNOUT_TRIP_SELECT]; // R17
    c.stack_fault_reset_enable = w2[cwd_pkg::B2_STVR]; // R18
    c.wp_active           = (self_write_protect_field != cwd_pkg::MODE_ALWAYS); // R19 R20
    unique case (self_write_protect_field)
      2'h2:    c.wp_top = LARGE_FLASH ? cwd_pkg::WP_LARGE_10 : cwd_pkg::WP_SMALL_10; // R19 R20
      2'h1:    c.wp_top = LARGE_FLASH ? cwd_pkg::WP_LARGE_01 : cwd_pkg::WP_SMALL_01; // R19 R20
      2'h0:    c.wp_top = LARGE_FLASH ? cwd_pkg::WP_LARGE_00 : cwd_pkg::WP_SMALL_00; // R19 R20
      default: c.wp_top = '0;
    endcase
    return c;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    logic        do_write;
    logic        do_read;
    logic [7:0]  wa;
    logic [31:0] rd;
    logic [1:0]  rr;
    logic [13:0] nv;
    logic [31:0] pc;
    st_next = st_reg;
    do_write = st_reg.axi.aw_held && st_reg.axi.w_held && !st_reg.axi.bvalid;
    do_read  = ARVALID && !st_reg.axi.rvalid;
    wa = st_reg.axi.awaddr;
    rd = '0;
    rr = cwd_pkg::RESP_OKAY;
    nv = '0;
    pc = '0;
    if (AWVALID && AWREADY) begin
      st_next.axi.awaddr  = AWADDR;
      st_next.axi.aw_held = 1'b1;
    end
    if (WVALID && WREADY) begin
      st_next.axi.wdata  = WDATA;
      st_next.axi.wstrb  = WSTRB;
      st_next.axi.w_held = 1'b1;
    end
    if (do_write) begin
      st_next.axi.aw_held = 1'b0;
      st_next.axi.w_held  = 1'b0;
      st_next.axi.bvalid  = 1'b1;
      st_next.axi.bresp   = cwd_pkg::RESP_OKAY;
      if (wa[7:4] == 4'h0 && wa[1:0] == 2'h0) begin
        pc = merge({18'h0, st_reg.user_id[wa[3:2]]}, st_reg.axi.wdata, st_reg.axi.wstrb);
        nv = pc[13:0];
        st_next.user_id[wa[3:2]] = nv; // R21
      end else if (wa == cwd_pkg::A_PROG_CTRL) begin
        pc = merge({30'h0, st_reg.lvp_session, st_reg.erase_pending},
                   st_reg.axi.wdata, st_reg.axi.wstrb);
        st_next.erase_pending = pc[cwd_pkg::PC_ERASE];
        st_next.lvp_session   = pc[cwd_pkg::PC_LVPSES];
      end else if (wa == cwd_pkg::A_CFG_ONE || wa == cwd_pkg::A_CFG_TWO) begin
        // Words are static until reset; a write only gets an error.
        st_next.axi.bresp = cwd_pkg::RESP_SLVERR; // R23
      end else begin
        st_next.axi.bresp = cwd_pkg::RESP_SLVERR;
      end
    end
    if (st_reg.axi.bvalid && BREADY) begin
      st_next.axi.bvalid = 1'b0;
    end
    if (do_read) begin
      if (ARADDR[7:4] == 4'h0 && ARADDR[1:0] == 2'h0) begin
        rd = {18'h0, st_reg.user_id[ARADDR[3:2]]}; // R21
      end else if (ARADDR == cwd_pkg::A_PART_ID) begin
        rd = {18'h0, PART_CODE, SILICON_STEP}; // R22
      end else if (ARADDR == cwd_pkg::A_CFG_ONE) begin
        rd = {18'h0, st_reg.cfg_one | cwd_pkg::CFG_ONE_UNIMPL}; // R1 R2
      end else if (ARADDR == cwd_pkg::A_CFG_TWO) begin
        rd = {18'h0, st_reg.cfg_two | cwd_pkg::CFG_TWO_UNIMPL}; // R1 R2
      end else if (ARADDR == cwd_pkg::A_STATUS) begin
        rd = {29'h0, st_reg.refused, st_reg.ctrl.code_protect_active, st_reg.port_blocked};
      end else if (ARADDR == cwd_pkg::A_PROG_CTRL) begin
        rd = {30'h0, st_reg.lvp_session, st_reg.erase_pending};
      end else begin
        rr = cwd_pkg::RESP_SLVERR;
      end
      st_next.axi.rvalid = 1'b1;
      st_next.axi.rdata  = rd;
      st_next.axi.rresp  = rr;
    end else if (st_reg.axi.rvalid && RREADY) begin
      st_next.axi.rvalid = 1'b0;
    end
    st_next.port_blocked = EXT_PORT_REQ && st_reg.ctrl.code_protect_active; // R7
    st_next.port_rdata   = st_reg.ctrl.code_protect_active ? '0 : FLASH_RDATA; // R7
    if (RESET) begin
      // Capture the stored words during reset; the bulk erase path restores blank words. R23
      st_next.cfg_one = (st_reg.erase_pending ? cwd_pkg::WORD_ERASED : NV_CFG_ONE)
                        | cwd_pkg::CFG_ONE_UNIMPL; // R1 R2 R8
      st_next.cfg_two = (st_reg.erase_pending ? cwd_pkg::WORD_ERASED : NV_CFG_TWO)
                        | cwd_pkg::CFG_TWO_UNIMPL; // R1 R2
      // A low-voltage session cannot clear the low-voltage enable.
      st_next.refused = st_reg.lvp_session && !NV_CFG_TWO[cwd_pkg::B2_LVP]
                        && st_reg.cfg_two[cwd_pkg::B2_LVP];
      if (st_next.refused) begin
        st_next.cfg_two[cwd_pkg::B2_LVP] = 1'b1; // R14
      end
      // Protection may only be lifted by a bulk erase, not a rewrite of the bit.
      if (!st_reg.erase_pending && st_reg.ctrl.code_protect_active) begin
        st_next.cfg_one[cwd_pkg::B1_CP] = 1'b0; // R8
      end
      st_next.ctrl = decode(st_next.cfg_one, st_next.cfg_two);
      st_next.erase_pending = 1'b0;
      st_next.axi = '0;
      st_next.port_blocked = 1'b0;
      st_next.port_rdata = '0;
    end
  end

  always_ff @(posedge MCLK) begin
    st_reg <= st_next;
  end

  assign AWREADY = !st_reg.axi.aw_held && !RESET;
  assign WREADY  = !st_reg.axi.w_held && !RESET;
  assign ARREADY = !st_reg.axi.rvalid && !RESET;
  assign BVALID  = st_reg.axi.bvalid;
  assign BRESP   = st_reg.axi.bresp;
  assign RVALID  = st_reg.axi.rvalid;
  assign RDATA   = st_reg.axi.rdata;
  assign RRESP   = st_reg.axi.rresp;
  assign CTRL    = st_reg.ctrl;
  assign EXT_PORT_RDATA   = st_reg.port_rdata; // R7
  assign EXT_PORT_BLOCKED = st_reg.port_blocked; // R7
  assign SELF_WRITE_BLOCKED = st_reg.ctrl.wp_active
                              && SELF_WRITE_ADDR <= {2'b00, st_reg.ctrl.wp_top}; // R19 R20
  assign STACK_FAULT_RESET = STACK_FAULT && st_reg.ctrl.stack_fault_reset_enable; // R18
  assign BROWNOUT_ACTIVE = st_reg.ctrl.bor_always || (st_reg.ctrl.bor_run_only && !IN_SLEEP)
                           || (st_reg.ctrl.bor_software && SOFTWARE_BROWNOUT_ENABLE); // R4
  assign WATCHDOG_ACTIVE = st_reg.ctrl.wdt_always || (st_reg.ctrl.wdt_run_only && !IN_SLEEP)
                           || (st_reg.ctrl.wdt_software && SOFTWARE_WATCHDOG_ENABLE); // R11
endmodule // cwd_config_word_decoder

// ==== src/cwd_pkg.sv ====
// Overview of operation
// R1: Word one sits at 8007h, word two at 8008h; all options decode from them.
// R2: Unimplemented bits of both words always read back as one.
// R3: Word one bit 11 low routes system clock to its pin; high gives I/O.
// R4: Brown-out field: 11 on, 10 on except sleep, 01 software bit, 00 off.
// R5: Brown-out enable never turns on the power-up timer by itself.
// R6: Code-protect bit 7 low enables protection, high disables it.
// R7: Protected memory blocks external port reads and writes; reads give zeros.
// R8: Protection clears only through a bulk erase, never a selective rewrite.
// R9: Reset-pin bit ignored under low-voltage programming; else reset pin or input.
// R10: Power-up timer bit 5 low enables the timer, high disables it.
// R11: Watchdog field: 11 on, 10 on except sleep, 01 software bit, 00 off.
// R12: Oscillator field picks external high, medium, low power, or internal oscillator.
// R13: Oscillator field sets the clock source used at power-up.
// R14: Word two bit 13 enables low-voltage programming; not clearable in such session.
// R15: Debugger bit low dedicates both programming pins to the debugger.
// R16: Low-power brown-out bit 11 low enables it, high disables it.
// R17: Brown-out trip bit 10 high selects low trip, low selects high trip.
// R18: Stack-fault bit 9 high resets on stack overflow or underflow.
// R19: Small variant write protection: none, 000-1FFh, 000-7FFh, or 000-FFFh.
// R20: Large variant write protection: none, 0000-01FFh, 0000-0FFFh, or 0000-1FFFh.
// R21: Four user identification words at 8000h-8003h, readable and writable.
// R22: Identification word at 8006h holds nine-bit part code and five-bit revision.
// R23: Words latch from storage during reset and stay static until next reset.
package cwd_pkg;
  localparam logic [15:0] USER_ID_BASE   = 16'h8000;
  localparam logic [15:0] PART_ID_ADDR   = 16'h8006;
  localparam logic [15:0] CFG_ONE_ADDR   = 16'h8007;
  localparam logic [15:0] CFG_TWO_ADDR   = 16'h8008;
  localparam int          USER_ID_COUNT  = 4;
  // AXI byte addresses of the register window.
  localparam logic [7:0]  A_USER_ID0     = 8'h00;
  localparam logic [7:0]  A_PART_ID      = 8'h18;
  localparam logic [7:0]  A_CFG_ONE      = 8'h1C;
  localparam logic [7:0]  A_CFG_TWO      = 8'h20;
  localparam logic [7:0]  A_STATUS       = 8'h24;
  localparam logic [7:0]  A_PROG_CTRL    = 8'h28;
  localparam logic [13:0] CFG_ONE_UNIMPL = 14'h3104;
  localparam logic [13:0] CFG_TWO_UNIMPL = 14'h01FC;
  localparam logic [13:0] WORD_ERASED    = 14'h3FFF;
  localparam int B1_CLOCK_OUTPUT_PIN = 11;
  localparam int B1_BOR_LO = 9;
  localparam int B1_CP     = 7;
  localparam int B1_RSTPIN = 6;
  localparam int B1_POWERUP_TIMER   = 5;
  localparam int B1_WDT_LO = 3;
  localparam int B1_OSC_LO = 0;
  localparam int B2_LVP    = 13;
  localparam int B2_DEBUG  = 12;
  localparam int B2_LOW_POWER_BROWNOUT_ENABLE_N  = 11;
  localparam int B2_BROWNOUT_TRIP_SELECT   = 10;
  localparam int B2_STVR   = 9;
  localparam int B2_WRT_LO = 0;
  localparam int PC_ERASE  = 0;
  localparam int PC_LVPSES = 1;
  localparam logic [1:0] MODE_ALWAYS = 2'h3;
  localparam logic [1:0] MODE_RUN    = 2'h2;
  localparam logic [1:0] MODE_SW     = 2'h1;
  localparam logic [12:0] WP_SMALL_10 = 13'h01FF;
  localparam logic [12:0] WP_SMALL_01 = 13'h07FF;
  localparam logic [12:0] WP_SMALL_00 = 13'h0FFF;
  localparam logic [12:0] WP_LARGE_10 = 13'h01FF;
  localparam logic [12:0] WP_LARGE_01 = 13'h0FFF;
  localparam logic [12:0] WP_LARGE_00 = 13'h1FFF;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    OSC_INTERNAL, OSC_EXT_LOW, OSC_EXT_MEDIUM, OSC_EXT_HIGH
  } cwd_osc_t;

  typedef struct packed {
    logic       clock_output_route;
    logic       bor_always;
    logic       bor_run_only;
    logic       bor_software;
    logic       code_protect_active;
    logic       pin_is_reset;
    logic       pin_pullup_forced;
    logic       powerup_timer_on;
    logic       wdt_always;
    logic       wdt_run_only;
    logic       wdt_software;
    cwd_osc_t   osc_mode;
    logic       clock_input_is_io;
    logic       low_voltage_program_enable;
    logic       debugger_owns_pins;
    logic       low_power_bor_on;
    logic       bor_low_trip;
    logic       stack_fault_reset_enable;
    logic       wp_active;
    logic [12:0] wp_top;
  } cwd_ctrl_t;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        aw_held;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        w_held;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } cwd_axi_t;
endpackage

// ==== verif/cwd_checker_sva.sv ====
module cwd_decoder_checker (
  input wire logic               MCLK,
  input wire logic               RESET,
  input wire logic               IN_SLEEP,
  input wire logic               SOFTWARE_BROWNOUT_ENABLE,
  input wire logic               SOFTWARE_WATCHDOG_ENABLE,
  input wire logic               STACK_FAULT,
  input wire logic               EXT_PORT_REQ,
  input wire logic [14:0]        SELF_WRITE_ADDR,
  input wire logic [13:0]        FLASH_RDATA,
  input wire logic [13:0]        EXT_PORT_RDATA,
  input wire logic               EXT_PORT_BLOCKED,
  input wire logic               SELF_WRITE_BLOCKED,
  input wire logic               STACK_FAULT_RESET,
  input wire logic               BROWNOUT_ACTIVE,
  input wire logic               WATCHDOG_ACTIVE,
  input wire cwd_pkg::cwd_ctrl_t CTRL,
  input wire logic               ARVALID,
  input wire logic               ARREADY,
  input wire logic               RVALID
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  sequence s_settled;
    !$past(RESET) && !$past(RESET, 2);
  endsequence
  sequence s_ar_taken;
    ARVALID && ARREADY;
  endsequence
  property p_bor_mode;
    BROWNOUT_ACTIVE == (CTRL.bor_always || (CTRL.bor_run_only && !IN_SLEEP)
      || (CTRL.bor_software && SOFTWARE_BROWNOUT_ENABLE));
  endproperty
  a_bor_mode: assert property (p_bor_mode) else $error("brownout level wrong");
  property p_wdt_mode;
    WATCHDOG_ACTIVE == (CTRL.wdt_always || (CTRL.wdt_run_only && !IN_SLEEP)
      || (CTRL.wdt_software && SOFTWARE_WATCHDOG_ENABLE));
  endproperty
  a_wdt_mode: assert property (p_wdt_mode) else $error("watchdog level wrong");
  property p_stack;
    STACK_FAULT_RESET == (STACK_FAULT && CTRL.stack_fault_reset_enable);
  endproperty
  a_stack: assert property (p_stack) else $error("stack fault reset wrong");
  property p_self_write;
    SELF_WRITE_BLOCKED == (CTRL.wp_active && (SELF_WRITE_ADDR <= {2'h0, CTRL.wp_top}));
  endproperty
  a_self_write: assert property (p_self_write) else $error("self write block wrong");
  property p_port_block;
    s_settled |-> EXT_PORT_BLOCKED == ($past(EXT_PORT_REQ) && CTRL.code_protect_active);
  endproperty
  a_port_block: assert property (p_port_block) else $error("port block wrong");
  property p_port_data;
    s_settled |-> EXT_PORT_RDATA == (CTRL.code_protect_active ? 14'h0 : $past(FLASH_RDATA));
  endproperty
  a_port_data: assert property (p_port_data) else $error("port read data wrong");
  property p_static;
    s_settled |-> $stable(CTRL);
  endproperty
  a_static: assert property (p_static) else $error("controls changed");
  property p_rd_answer;
    s_ar_taken |=> RVALID;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
endmodule // cwd_decoder_checker

bind cwd_config_word_decoder cwd_decoder_checker u_chk (.MCLK(MCLK), .RESET(RESET),
  .IN_SLEEP(IN_SLEEP), .SOFTWARE_BROWNOUT_ENABLE(SOFTWARE_BROWNOUT_ENABLE),
  .SOFTWARE_WATCHDOG_ENABLE(SOFTWARE_WATCHDOG_ENABLE), .STACK_FAULT(STACK_FAULT),
  .EXT_PORT_REQ(EXT_PORT_REQ), .SELF_WRITE_ADDR(SELF_WRITE_ADDR), .FLASH_RDATA(FLASH_RDATA),
  .EXT_PORT_RDATA(EXT_PORT_RDATA), .EXT_PORT_BLOCKED(EXT_PORT_BLOCKED),
  .SELF_WRITE_BLOCKED(SELF_WRITE_BLOCKED), .STACK_FAULT_RESET(STACK_FAULT_RESET),
  .BROWNOUT_ACTIVE(BROWNOUT_ACTIVE), .WATCHDOG_ACTIVE(WATCHDOG_ACTIVE), .CTRL(CTRL),
  .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID));

// ==== verif/testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic               mclk = 1'h0, reset = 1'h1;
  logic [13:0]        nv1 = 14'h3FFF, nv2 = 14'h3FFF, flash = 14'h0, ep_rdata;
  logic               sbor = 1'h0, swdt = 1'h0, pup = 1'h0, sleep = 1'h0;
  logic               sfault = 1'h0, ep_req = 1'h0;
  logic [14:0]        swa = 15'h0;
  logic               ep_blk, sw_blk, sf_rst, bor_act, wdt_act;
  cwd_pkg::cwd_ctrl_t ctrl, ctrl_l;
  logic [7:0]         awaddr = 8'h0, araddr = 8'h0;
  logic [31:0]        wdata = 32'h0, rdata, seed = 32'hB, bgs = 32'hB;
  logic [3:0]         wstrb = 4'h0;
  logic               awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic               arvalid = 1'h0, rready = 1'h0;
  logic               awready, wready, bvalid, arready, rvalid;
  logic [1:0]         bresp, rresp;
  logic [13:0]        uid [4];
  int                 err_count = 0, n_tests = 0;

  always #50 mclk = ~mclk;

  cwd_config_word_decoder dut (.MCLK(mclk), .RESET(reset), .NV_CFG_ONE(nv1),
    .NV_CFG_TWO(nv2), .SOFTWARE_BROWNOUT_ENABLE(sbor), .SOFTWARE_WATCHDOG_ENABLE(swdt),
    .PORT_PULLUP_BIT(pup), .IN_SLEEP(sleep), .STACK_FAULT(sfault), .EXT_PORT_REQ(ep_req),
    .SELF_WRITE_ADDR(swa), .FLASH_RDATA(flash), .EXT_PORT_RDATA(ep_rdata),
    .EXT_PORT_BLOCKED(ep_blk), .SELF_WRITE_BLOCKED(sw_blk), .STACK_FAULT_RESET(sf_rst),
    .BROWNOUT_ACTIVE(bor_act), .WATCHDOG_ACTIVE(wdt_act), .CTRL(ctrl), .AWADDR(awaddr),
    .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
    .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
    .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
    .RREADY(rready));

  // The large variant shares the word and pin inputs, with its bus tied idle; only its decoded ranges are compared.
  cwd_config_word_decoder #(.LARGE_FLASH(1'b1)) dut_large (.MCLK(mclk), .RESET(reset),
    .NV_CFG_ONE(nv1), .NV_CFG_TWO(nv2), .SOFTWARE_BROWNOUT_ENABLE(sbor),
    .SOFTWARE_WATCHDOG_ENABLE(swdt), .PORT_PULLUP_BIT(pup), .IN_SLEEP(sleep),
    .STACK_FAULT(sfault), .EXT_PORT_REQ(ep_req), .SELF_WRITE_ADDR(swa), .FLASH_RDATA(flash),
    .EXT_PORT_RDATA(), .EXT_PORT_BLOCKED(), .SELF_WRITE_BLOCKED(), .STACK_FAULT_RESET(),
    .BROWNOUT_ACTIVE(), .WATCHDOG_ACTIVE(), .CTRL(ctrl_l), .AWADDR(8'h0), .AWVALID(1'h0),
    .AWREADY(), .WDATA(32'h0), .WSTRB(4'h0), .WVALID(1'h0), .WREADY(), .BRESP(),
    .BVALID(), .BREADY(1'h0), .ARADDR(8'h0), .ARVALID(1'h0), .ARREADY(), .RDATA(),
    .RRESP(), .RVALID(), .RREADY(1'h0));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic cwd_pkg::cwd_ctrl_t exp_ctrl(input logic [13:0] a, b,
      input cwd_pkg::cwd_ctrl_t g);
    cwd_pkg::cwd_ctrl_t e;
    e = g;
    e.clock_output_route = !a[11];
    {e.bor_always, e.bor_run_only, e.bor_software} = {a[10:9] == 2'h3, a[10:9] == 2'h2,
      a[10:9] == 2'h1};
    e.code_protect_active = !a[7];
    {e.pin_is_reset, e.pin_pullup_forced} = {2{b[13] | a[6]}};
    e.powerup_timer_on = !a[5];
    {e.wdt_always, e.wdt_run_only, e.wdt_software} = {a[4:3] == 2'h3, a[4:3] == 2'h2,
      a[4:3] == 2'h1};
    e.osc_mode = cwd_pkg::cwd_osc_t'(a[1:0]);
    e.clock_input_is_io = a[1:0] == 2'h0;
    e.low_voltage_program_enable = b[13];
    e.debugger_owns_pins = !b[12];
    e.low_power_bor_on = !b[11];
    e.bor_low_trip = b[10];
    e.stack_fault_reset_enable = b[9];
    e.wp_active = b[1:0] != 2'h3;
    e.wp_top = 13'h0;
    if (e.wp_active) e.wp_top = b[1] ? 13'h01FF : (b[0] ? 13'h07FF : 13'h0FFF);
    return e;
  endfunction

  task automatic check(input string nm, input logic [63:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic do_reset(input int n);
    reset <= 1'h1;
    repeat (n) @(posedge mclk);
    reset <= 1'h0;
    repeat (3) @(posedge mclk);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'h0;
    @(posedge mclk);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    @(posedge mclk);
  endtask

  // Self-write addresses often land on the protected range edge.
  always @(posedge mclk) begin
    bgs = lfsr(bgs);
    {sbor, swdt, pup, sleep, sfault, ep_req} <= bgs[5:0];
    swa <= bgs[6] ? {2'h0, ctrl.wp_top} + 15'(bgs[7]) : bgs[30:16];
    flash <= bgs[29:16];
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    do_reset(16);
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      nv1 <= {seed[13:11], i[3:2], seed[8], 1'h1, seed[6:5], i[1:0] ^ i[3:2], seed[2], i[1:0]};
      nv2 <= {seed[29:18], i[3:2]};
      do_reset(2);
      check("controls", ctrl, exp_ctrl(nv1, nv2, ctrl));
      check("large range", {ctrl_l.wp_active, ctrl_l.wp_top}, nv2[1:0] == 2'h3 ? 14'h0 :
        {1'h1, nv2[1] ? 13'h01FF : (nv2[0] ? 13'h0FFF : 13'h1FFF)});
      axi_rd(cwd_pkg::A_CFG_ONE, d, r);
      check("word one", d, {18'h0, nv1 | cwd_pkg::CFG_ONE_UNIMPL});
      axi_rd(cwd_pkg::A_CFG_TWO, d, r);
      check("word two", d, {18'h0, nv2 | cwd_pkg::CFG_TWO_UNIMPL});
    end
    axi_rd(cwd_pkg::A_PART_ID, d, r);
    check("part id", d, {18'h0, 9'h0A5, 5'h01});
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      uid[k] = seed[13:0];
      axi_wr(8'(4 * k), seed, r);
    end
    for (int k = 0; k < 4; k++) begin
      axi_rd(8'(4 * k), d, r);
      check("user id", d, {18'h0, uid[k]});
    end
    axi_rd(8'h40, d, r);
    check("unmapped read", {r, d}, {cwd_pkg::RESP_SLVERR, 32'h0});
    axi_wr(cwd_pkg::A_CFG_ONE, 32'h0, r);
    check("word write", r, cwd_pkg::RESP_SLVERR);
    nv1 <= 14'h3F7F;
    nv2 <= 14'h3FFF;
    do_reset(2);
    check("protect on", ctrl.code_protect_active, 1'h1);
    check("port data", ep_rdata, 14'h0);
    nv1 <= 14'h3FFF;
    do_reset(2);
    check("protect kept", ctrl.code_protect_active, 1'h1);
    axi_wr(cwd_pkg::A_PROG_CTRL, 32'h1, r);
    do_reset(2);
    check("protect erased", ctrl.code_protect_active, 1'h0);
    axi_rd(cwd_pkg::A_CFG_ONE, d, r);
    check("erased word", d, {18'h0, cwd_pkg::WORD_ERASED});
    axi_wr(cwd_pkg::A_PROG_CTRL, 32'h2, r);
    nv2 <= 14'h1FFF;
    do_reset(2);
    check("lvp kept", ctrl.low_voltage_program_enable, 1'h1);
    axi_rd(cwd_pkg::A_STATUS, d, r);
    check("lvp refused", d[2], 1'h1);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    summarize();
  end
endmodule // testbench
